// *** verilog/dxbl_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef DXBL_REGS_SVH
`define DXBL_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define DXBL_OFS_CMD_MATCH 8'h0E
`define DXBL_OFS_GRP_MATCH 8'h0F
`define DXBL_OFS_BUF_STATE 8'h12
`define DXBL_OFS_NEXT_CMD 8'h13

// ****************************************
// Field positions
// ****************************************
`define DXBL_F_FREE_LSB 6
`define DXBL_F_USER_LSB 4
`define DXBL_F_NEXT_LSB 2
`define DXBL_F_DATA_LSB 0
`define DXBL_F_NEW_USER_BIT 2

// ****************************************
// Reset values
// ****************************************
`define DXBL_RST_MATCH 8'h00
`define DXBL_RST_FREE 2'h2
`define DXBL_RST_USER 2'h3
`define DXBL_RST_NEXT 2'h0
`define DXBL_RST_DATA 2'h1
`define DXBL_PTR_NIL 2'h0

// ****************************************
// Timing
// ****************************************
`define DXBL_CLK_PERIOD_NS 50
`define DXBL_WD_TICK_NS 1000
`define DXBL_WD_TICK_CYC ((`DXBL_WD_TICK_NS + `DXBL_CLK_PERIOD_NS - 1) / `DXBL_CLK_PERIOD_NS)
`define DXBL_SYNC_UNIT_DEN 12
`define DXBL_SYNC_UNIT_SCALED 1000
`define DXBL_CLK_STEP_SCALED (`DXBL_CLK_PERIOD_NS * `DXBL_SYNC_UNIT_DEN)

`endif

// *** verilog/dxbl_pkg.sv ***
// Types shared by the broadcast, link monitor and sync logic
package dxbl_pkg;
  localparam int DXBL_LINKS = 29;
  typedef logic [1:0] dxbl_ptr_t;
  typedef logic [7:0] dxbl_byte_t;
  typedef logic [DXBL_LINKS-1:0] dxbl_links_t;
  typedef struct packed {
    dxbl_byte_t cmd_match;
    dxbl_byte_t grp_match;
    dxbl_ptr_t buf_free;
    dxbl_ptr_t buf_user;
    dxbl_ptr_t buf_next;
    dxbl_ptr_t buf_data;
    dxbl_byte_t rdata;
    dxbl_links_t active;
    dxbl_links_t error;
    dxbl_links_t present;
    logic [4:0] wd_pre;
    logic [15:0] wd_cnt;
    logic pending;
    logic sync_hold;
    logic dx_irq;
    logic gc_irq;
    logic bc_irq;
    logic sync_pin;
    logic start;
  } dxbl_state_t;
  typedef struct packed {
    logic busy;
    logic [17:0] acc;
  } dxbl_pulse_t;
endpackage

// *** verilog/dxbl_sync_if.sv ***
// Carrier between the main block and its sync pulse timer
`timescale 1ns/100ps
interface dxbl_sync_if;
  logic start;
  logic [7:0] width;
  logic busy;
  modport ctl (output start, output width, input busy);
  modport tmr (input start, input width, output busy);
endinterface

// *** verilog/dxbl_sync_pulse.sv ***
// Sync pulse width timer in units of one twelfth of a microsecond
`timescale 1ns/100ps
`include "dxbl_regs.svh"
module dxbl_sync_pulse (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  dxbl_sync_if.tmr sync_if
);
  import dxbl_pkg::*;

  dxbl_pulse_t s_q;
  dxbl_pulse_t s_d;
  logic [17:0] limit;

  // Scaled by twelve so the fractional unit stays exact
  assign limit = 18'(sync_if.width) * 18'(`DXBL_SYNC_UNIT_SCALED);

  always_comb begin
    s_d = s_q;
    if (sync_if.start && sync_if.width != 8'h00) begin
      s_d.busy = 1'b1;
      s_d.acc = 18'(`DXBL_CLK_STEP_SCALED);
    end else if (s_q.busy) begin
      if (s_q.acc >= limit) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.acc = s_q.acc + 18'(`DXBL_CLK_STEP_SCALED);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_if.busy = s_q.busy;
endmodule

// *** verilog/dxbl_top.sv ***
// Broadcast buffer manager, publisher link monitor and sync generator
`timescale 1ns/100ps
`include "dxbl_regs.svh"
module dxbl_top (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Processor register port
  input wire dxbl_pkg::dxbl_byte_t reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire dxbl_pkg::dxbl_byte_t reg_wdata_in,
  output dxbl_pkg::dxbl_byte_t reg_rdata_out,
  // Mode bits
  input wire logic sync_enable_in,
  input wire logic spec_clear_mode_in,
  input wire logic exchange_interrupt_to_port_in,
  input wire logic sync_polarity_in,
  input wire dxbl_pkg::dxbl_byte_t sync_pulse_width_in,
  input wire logic output_data_mask_in,
  input wire logic output_data_ack_in,
  // Protocol engine events
  input wire logic cyclic_exchange_state_in,
  input wire logic [15:0] watchdog_interval_in,
  input wire logic bcast_rx_ok_in,
  input wire logic bcast_rx_err_in,
  input wire logic [4:0] bcast_link_in,
  input wire logic exchange_rx_in,
  input wire logic gc_rx_in,
  input wire dxbl_pkg::dxbl_byte_t gc_command_in,
  input wire dxbl_pkg::dxbl_byte_t gc_group_in,
  // Results
  output dxbl_pkg::dxbl_links_t link_active_out,
  output dxbl_pkg::dxbl_links_t link_error_out,
  output dxbl_pkg::dxbl_links_t data_present_out,
  output logic output_data_interrupt_out,
  output logic new_global_control_interrupt_out,
  output logic broadcast_out_interrupt_out,
  output logic sync_out
);
  import dxbl_pkg::*;

  // ****************************************
  // State
  // ****************************************
  dxbl_state_t s_q;
  dxbl_state_t s_d;
  dxbl_sync_if sync_if ();

  logic iso_mode;
  logic simple_mode;
  logic synch_hit;
  logic wd_expire;
  logic wd_tick;
  logic rd_cmd;
  logic wr_any;
  dxbl_links_t nxt_active;
  dxbl_links_t nxt_error;
  dxbl_links_t nxt_present;

  // ****************************************
  // Mode decode
  // ****************************************
  assign iso_mode = sync_enable_in && spec_clear_mode_in;
  assign simple_mode = exchange_interrupt_to_port_in && !sync_enable_in;

  // Both bytes must match; the sender keeps the layout
  assign synch_hit = gc_rx_in && (gc_command_in == s_q.cmd_match)
    && (gc_group_in == s_q.grp_match);

  assign rd_cmd = reg_rd_in && (reg_addr_in == `DXBL_OFS_NEXT_CMD);
  assign wr_any = reg_wr_in;

  // ****************************************
  // Watchdog interval
  // ****************************************
  // One prescaler wrap per microsecond of interval
  assign wd_tick = (s_q.wd_pre == 5'(`DXBL_WD_TICK_CYC - 1));
  // Interval of zero means the master left the watchdog off
  assign wd_expire = cyclic_exchange_state_in && (watchdog_interval_in != 16'h0000)
    && wd_tick
    && (s_q.wd_cnt >= watchdog_interval_in - 16'h0001);

  // ****************************************
  // Per-link status
  // ****************************************
  generate
    for (genvar i = 0; i < DXBL_LINKS; i++) begin : g_link
      logic hit;
      logic a;
      logic e;
      logic p;
      assign hit = (bcast_link_in == 5'(i));
      always_comb begin
        a = s_q.active[i];
        e = s_q.error[i];
        p = s_q.present[i];
        if (wd_expire) begin
          if (s_q.present[i]) begin
            a = 1'b1;
            e = 1'b0;
            p = 1'b0;
          end else if (s_q.error[i]) begin
            a = 1'b0;
            e = 1'b0;
            p = 1'b0;
          end else begin
            a = 1'b0;
          end
        end
        // A receipt in the expiry cycle still counts for the new period
        if (hit && bcast_rx_err_in) begin
          a = 1'b0;
          e = 1'b1;
          p = 1'b0;
        end else if (hit && bcast_rx_ok_in) begin
          e = 1'b0;
          p = 1'b1;
        end
      end
      assign nxt_active[i] = a;
      assign nxt_error[i] = e;
      assign nxt_present[i] = p;
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    dxbl_ptr_t tmp;
    logic changed;
    s_d = s_q;
    tmp = `DXBL_PTR_NIL;
    changed = 1'b0;
    s_d.dx_irq = 1'b0;
    s_d.gc_irq = 1'b0;
    s_d.bc_irq = 1'b0;
    s_d.start = 1'b0;

    // ****************************************
    // Match registers
    // ****************************************
    if (wr_any && reg_addr_in == `DXBL_OFS_CMD_MATCH) begin
      s_d.cmd_match = reg_wdata_in;
    end
    if (wr_any && reg_addr_in == `DXBL_OFS_GRP_MATCH) begin
      s_d.grp_match = reg_wdata_in;
    end

    // ****************************************
    // Watchdog prescaler and interval count
    // ****************************************
    if (!cyclic_exchange_state_in || wd_expire) begin
      s_d.wd_pre = 5'h00;
      s_d.wd_cnt = 16'h0000;
    end else if (wd_tick) begin
      s_d.wd_pre = 5'h00;
      s_d.wd_cnt = s_q.wd_cnt + 16'h0001;
    end else begin
      s_d.wd_pre = s_q.wd_pre + 5'h01;
    end
    s_d.active = nxt_active;
    s_d.error = nxt_error;
    s_d.present = nxt_present;

    // ****************************************
    // Buffer rotation on good receipt; a faulty one reuses the data buffer
    // ****************************************
    if (bcast_rx_ok_in && !bcast_rx_err_in) begin
      tmp = s_d.buf_next;
      s_d.buf_next = s_d.buf_data;
      if (tmp == `DXBL_PTR_NIL) begin
        s_d.buf_data = s_d.buf_free;
        s_d.buf_free = `DXBL_PTR_NIL;
      end else begin
        s_d.buf_data = tmp;
      end
      s_d.bc_irq = 1'b1;
    end

    // ****************************************
    // Processor fetch of the next buffer
    // ****************************************
    if (rd_cmd && s_d.buf_next != `DXBL_PTR_NIL) begin
      if (s_d.buf_free == `DXBL_PTR_NIL) begin
        s_d.buf_free = s_d.buf_user;
      end
      s_d.buf_user = s_d.buf_next;
      s_d.buf_next = `DXBL_PTR_NIL;
      changed = 1'b1;
    end

    // ****************************************
    // Read data, registered one cycle after the strobe
    // ****************************************
    if (reg_rd_in) begin
      case (reg_addr_in)
        `DXBL_OFS_CMD_MATCH: begin
          s_d.rdata = s_q.cmd_match;
        end
        `DXBL_OFS_GRP_MATCH: begin
          s_d.rdata = s_q.grp_match;
        end
        `DXBL_OFS_BUF_STATE: begin
          s_d.rdata = {s_q.buf_free, s_q.buf_user,
            s_q.buf_next, s_q.buf_data};
        end
        `DXBL_OFS_NEXT_CMD: begin
          s_d.rdata = {5'h00, changed, s_d.buf_user};
        end
        // Unmapped offsets read as zero
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end

    // ****************************************
    // Every global control reaches the control interrupt
    // ****************************************
    if (gc_rx_in) begin
      s_d.gc_irq = 1'b1;
    end

    // ****************************************
    // Exchange telegram and SYNCH handling
    // ****************************************
    if (simple_mode) begin
      if (synch_hit) begin
        if (s_q.pending || exchange_rx_in) begin
          s_d.dx_irq = 1'b1;
          if (!output_data_mask_in) begin
            s_d.sync_hold = 1'b1;
          end
        end
        s_d.pending = 1'b0;
      end else if (exchange_rx_in) begin
        s_d.pending = 1'b1;
      end
    end else begin
      s_d.pending = 1'b0;
      if (exchange_rx_in) begin
        s_d.dx_irq = 1'b1;
      end
      if (iso_mode && synch_hit) begin
        s_d.start = 1'b1;
      end
    end

    // ****************************************
    // Held indication drops on acknowledge; a new set wins
    // ****************************************
    if (output_data_ack_in && !(s_d.sync_hold && !s_q.sync_hold)) begin
      s_d.sync_hold = 1'b0;
    end
    if (!simple_mode || output_data_mask_in) begin
      s_d.sync_hold = 1'b0;
    end

    // ****************************************
    // Output pin level
    // ****************************************
    if (simple_mode) begin
      s_d.sync_pin = s_d.sync_hold ~^ sync_polarity_in;
    end else begin
      // Timer reports busy a cycle after start; a zero width shows start alone
      s_d.sync_pin = (iso_mode && (sync_if.busy || s_q.start))
        ~^ sync_polarity_in;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
      // Three buffers: one free, one with the user, one taking data
      s_q.cmd_match <= `DXBL_RST_MATCH;
      s_q.grp_match <= `DXBL_RST_MATCH;
      s_q.buf_free <= `DXBL_RST_FREE;
      s_q.buf_user <= `DXBL_RST_USER;
      s_q.buf_next <= `DXBL_RST_NEXT;
      s_q.buf_data <= `DXBL_RST_DATA;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Pulse timer
  // ****************************************
  assign sync_if.start = s_q.start;
  // Width is taken live, so a change mid-pulse stretches or cuts it
  assign sync_if.width = sync_pulse_width_in;

  dxbl_sync_pulse u_pulse (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .sync_if(sync_if.tmr)
  );

  // ****************************************
  // Outputs
  // ****************************************
  // Every output leaves straight from the state register
  assign reg_rdata_out = s_q.rdata;
  assign link_active_out = s_q.active;
  assign link_error_out = s_q.error;
  assign data_present_out = s_q.present;
  assign output_data_interrupt_out = s_q.dx_irq;
  assign new_global_control_interrupt_out = s_q.gc_irq;
  assign broadcast_out_interrupt_out = s_q.bc_irq;
  assign sync_out = s_q.sync_pin;
endmodule

// *** tb/dxbl_top_sva.sv ***
// Port checker for the broadcast, link and sync block
`timescale 1ns/100ps
module dxbl_top_chk (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire dxbl_pkg::dxbl_byte_t reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire dxbl_pkg::dxbl_byte_t reg_wdata_in,
  input wire dxbl_pkg::dxbl_byte_t reg_rdata_out,
  input wire logic sync_enable_in,
  input wire logic spec_clear_mode_in,
  input wire logic exchange_interrupt_to_port_in,
  input wire logic sync_polarity_in,
  input wire dxbl_pkg::dxbl_byte_t sync_pulse_width_in,
  input wire logic output_data_mask_in,
  input wire logic bcast_rx_ok_in,
  input wire logic bcast_rx_err_in,
  input wire logic [4:0] bcast_link_in,
  input wire logic exchange_rx_in,
  input wire logic gc_rx_in,
  input wire dxbl_pkg::dxbl_byte_t gc_command_in,
  input wire dxbl_pkg::dxbl_byte_t gc_group_in,
  input wire dxbl_pkg::dxbl_links_t link_active_out,
  input wire dxbl_pkg::dxbl_links_t link_error_out,
  input wire dxbl_pkg::dxbl_links_t data_present_out,
  input wire logic output_data_interrupt_out,
  input wire logic new_global_control_interrupt_out,
  input wire logic broadcast_out_interrupt_out,
  input wire logic sync_out
);
  import dxbl_pkg::*;
  // ****
  // Shadow of the match registers, so SYNCH is known here
  // ****
  dxbl_byte_t cm_q;
  dxbl_byte_t gm_q;
  wire logic iso = sync_enable_in && spec_clear_mode_in;
  wire logic simple = exchange_interrupt_to_port_in && !sync_enable_in;
  wire logic synch = gc_rx_in && gc_command_in == cm_q && gc_group_in == gm_q;
  wire logic good = bcast_rx_ok_in && !bcast_rx_err_in;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cm_q <= 8'h00;
      gm_q <= 8'h00;
    end else if (reg_wr_in && reg_addr_in == 8'h0E) begin
      cm_q <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == 8'h0F) begin
      gm_q <= reg_wdata_in;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_cmd_zero;
    reg_rd_in && reg_addr_in == 8'h13 |=> reg_rdata_out[7:3] == 5'h00;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("cmd high bits set");
  property p_ok_stat;
    good |=> data_present_out[$past(bcast_link_in)] && !link_error_out[$past(bcast_link_in)];
  endproperty
  a_ok_stat: assert property (p_ok_stat) else $error("good receipt status");
  property p_err_stat;
    bcast_rx_err_in |=> link_error_out[$past(bcast_link_in)]
      && !link_active_out[$past(bcast_link_in)] && !data_present_out[$past(bcast_link_in)];
  endproperty
  a_err_stat: assert property (p_err_stat) else $error("faulty receipt status");
  property p_bc_irq;
    broadcast_out_interrupt_out == $past(good);
  endproperty
  a_bc_irq: assert property (p_bc_irq) else $error("broadcast irq");
  property p_gc_irq;
    new_global_control_interrupt_out == $past(gc_rx_in);
  endproperty
  a_gc_irq: assert property (p_gc_irq) else $error("global control irq");
  property p_iso;
    iso && synch && sync_pulse_width_in != 8'h00 |-> ##2 sync_out == sync_polarity_in;
  endproperty
  a_iso: assert property (p_iso) else $error("no iso pulse");
  property p_simple_dx;
    simple && exchange_rx_in && !gc_rx_in |=> !output_data_interrupt_out;
  endproperty
  a_simple_dx: assert property (p_simple_dx) else $error("early data irq");
  property p_simple_sync;
    simple && output_data_interrupt_out && !output_data_mask_in |-> sync_out == sync_polarity_in;
  endproperty
  a_simple_sync: assert property (p_simple_sync) else $error("no simple sync");
  c_iso: cover property (iso && synch);
  c_simple: cover property (simple && output_data_interrupt_out);
  c_err: cover property (bcast_rx_err_in);
endmodule
bind dxbl_top dxbl_top_chk dxbl_top_chk_inst (.*);

// *** tb/dxbl_pe_model.sv ***
// Far-side model: master and publishers raising telegram events
`timescale 1ns/100ps
module dxbl_pe_model (
  input wire logic sys_clk_in,
  output logic cyc_out,
  output logic [15:0] wd_out,
  output logic ok_out,
  output logic err_out,
  output logic [4:0] link_out,
  output logic exch_out,
  output logic gc_out,
  output dxbl_pkg::dxbl_byte_t cmd_out,
  output dxbl_pkg::dxbl_byte_t grp_out
);
  import dxbl_pkg::*;
  initial begin
    {cyc_out, wd_out, ok_out, err_out, link_out, exch_out, gc_out} = '0;
    {cmd_out, grp_out} = '0;
  end
  // Watchdog always on while monitoring is wanted
  task automatic mon(input logic on);
    @(posedge sys_clk_in);
    wd_out <= 16'h0002;
    cyc_out <= on;
  endtask
  task automatic bcast(input logic good, input logic [4:0] k, input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      ok_out <= good;
      err_out <= !good;
      link_out <= k;
    end
    @(posedge sys_clk_in);
    {ok_out, err_out} <= 2'h0;
    link_out <= ~k;
  endtask
  task automatic exch();
    @(posedge sys_clk_in);
    exch_out <= 1'b1;
    @(posedge sys_clk_in);
    exch_out <= 1'b0;
  endtask
  // Released lines show the inverse, not a stale match
  task automatic gc(input dxbl_byte_t c, input dxbl_byte_t g);
    @(posedge sys_clk_in);
    gc_out <= 1'b1;
    cmd_out <= c & 8'h3E;
    grp_out <= g | 8'h80;
    @(posedge sys_clk_in);
    gc_out <= 1'b0;
    cmd_out <= ~cmd_out;
    grp_out <= ~grp_out;
  endtask
endmodule

// *** tb/dxbl_top_test.sv ***
// Self-checking bench for the broadcast, link and sync block
`timescale 1ns/100ps
module dxbl_top_test;
  import dxbl_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  dxbl_byte_t reg_addr_in = 8'h00;
  dxbl_byte_t reg_wdata_in = 8'h00;
  dxbl_byte_t sync_pulse_width_in = 8'h06;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic sync_enable_in = 1'b0;
  logic spec_clear_mode_in = 1'b0;
  logic exchange_interrupt_to_port_in = 1'b0;
  logic sync_polarity_in = 1'b1;
  logic output_data_mask_in = 1'b0;
  logic output_data_ack_in = 1'b0;
  logic cyclic_exchange_state_in, bcast_rx_ok_in, bcast_rx_err_in, exchange_rx_in, gc_rx_in;
  logic [15:0] watchdog_interval_in;
  logic [4:0] bcast_link_in;
  dxbl_byte_t gc_command_in, gc_group_in, reg_rdata_out;
  dxbl_links_t link_active_out, link_error_out, data_present_out;
  logic output_data_interrupt_out, new_global_control_interrupt_out;
  logic broadcast_out_interrupt_out, sync_out;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  always #25 sys_clk_in = ~sys_clk_in;
  dxbl_top dxbl_top_inst (.*);
  dxbl_pe_model dxbl_pe_model_inst (.sys_clk_in(sys_clk_in), .cyc_out(cyclic_exchange_state_in),
    .wd_out(watchdog_interval_in), .ok_out(bcast_rx_ok_in), .err_out(bcast_rx_err_in),
    .link_out(bcast_link_in), .exch_out(exchange_rx_in), .gc_out(gc_rx_in),
    .cmd_out(gc_command_in), .grp_out(gc_group_in));
  // ****
  // Shared tasks
  // ****
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %0h got %0h", s, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input dxbl_byte_t a, input dxbl_byte_t d);
    @(posedge sys_clk_in);
    {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input dxbl_byte_t a, input dxbl_byte_t e);
    @(posedge sys_clk_in);
    {reg_addr_in, reg_rd_in} <= {a, 1'b1};
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk($sformatf("reg %0h", a), e, reg_rdata_out);
  endtask
  // Wrong group, wrong mode, no pending exchange or masked: no pulse may follow
  task automatic nosync(input dxbl_byte_t g, input logic dx);
    dxbl_pe_model_inst.gc(8'h14, g);
    #1;
    if (dx) chk("dx", 1'b0, output_data_interrupt_out);
    for (n = 0; n < 10; n++) begin
      if (sync_out === sync_polarity_in) break;
      tick(1);
    end
    chk("nosync", 10, n);
  endtask
  task automatic pw(input logic p, input dxbl_byte_t w);
    int lo;
    @(posedge sys_clk_in);
    {sync_polarity_in, sync_pulse_width_in} <= {p, w};
    tick(3);
    chk("idle", !p, sync_out);
    dxbl_pe_model_inst.gc(8'h14, 8'h81);
    #1;
    chk("gc_irq", 1'b1, new_global_control_interrupt_out);
    n = 0;
    repeat (30) begin
      tick(1);
      if (sync_out === p) n++;
    end
    // Pin holds for the start cycle plus the timer's rounded-up count
    lo = (w * 1000 + 599) / 600;
    chk("width", 1'b1, n >= lo && n <= lo + 1);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_bufs();
    rd(8'h12, 8'hB1);
    rd(8'h20, 8'h00);
    wr(8'h12, 8'h00);
    rd(8'h13, 8'h03);
    dxbl_pe_model_inst.bcast(1'b1, 5'd3, 1);
    #1;
    chk("bc_irq", 1'b1, broadcast_out_interrupt_out);
    rd(8'h12, 8'h36);
    rd(8'h13, 8'h05);
    rd(8'h12, 8'hD2);
    rd(8'h13, 8'h01);
    dxbl_pe_model_inst.bcast(1'b1, 5'd3, 2);
    rd(8'h12, 8'h1E);
    rd(8'h13, 8'h07);
    dxbl_pe_model_inst.bcast(1'b0, 5'd4, 1);
    rd(8'h12, 8'h72);
  endtask
  task automatic t_links();
    dxbl_pe_model_inst.mon(1'b1);
    dxbl_pe_model_inst.bcast(1'b1, 5'd3, 1);
    for (n = 0; n < 60 && link_active_out[3] !== 1'b1; n++) tick(1);
    chk("act3", 1'b1, link_active_out[3]);
    chk("pres3", 1'b0, data_present_out[3]);
    dxbl_pe_model_inst.bcast(1'b0, 5'd5, 1);
    #1;
    for (n = 0; n < 60 && link_error_out[5] === 1'b1; n++) tick(1);
    chk("period", 40, n + 2);
    chk("act3", 1'b0, link_active_out[3]);
    chk("lnk5", 2'h0, {link_active_out[5], data_present_out[5]});
    dxbl_pe_model_inst.mon(1'b0);
  endtask
  task automatic t_sync();
    wr(8'h0E, 8'h14);
    wr(8'h0F, 8'h81);
    rd(8'h0F, 8'h81);
    @(posedge sys_clk_in);
    {sync_enable_in, spec_clear_mode_in} <= 2'h3;
    pw(1'b1, 8'h06);
    pw(1'b0, 8'h03);
    nosync(8'h82, 1'b0);
    @(posedge sys_clk_in);
    {spec_clear_mode_in, sync_polarity_in} <= 2'h1;
    nosync(8'h81, 1'b0);
    @(posedge sys_clk_in);
    {sync_enable_in, exchange_interrupt_to_port_in} <= 2'h1;
    dxbl_pe_model_inst.exch();
    tick(1);
    chk("dx", 1'b0, output_data_interrupt_out);
    dxbl_pe_model_inst.gc(8'h14, 8'h81);
    #1;
    chk("dx", 1'b1, output_data_interrupt_out);
    chk("gc", 1'b1, new_global_control_interrupt_out);
    tick(6);
    chk("held", 1'b1, sync_out);
    @(posedge sys_clk_in);
    output_data_ack_in <= 1'b1;
    @(posedge sys_clk_in);
    output_data_ack_in <= 1'b0;
    tick(1);
    chk("ack", 1'b0, sync_out);
    nosync(8'h81, 1'b1);
    @(posedge sys_clk_in);
    output_data_mask_in <= 1'b1;
    dxbl_pe_model_inst.exch();
    nosync(8'h81, 1'b0);
  endtask
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    t_bufs();
    t_links();
    t_sync();
    complete_run();
  end
endmodule
